/* verilog/sbc_mode_map.vh */
// Constants for the restart and fail-safe mode sequencer
`ifndef SBC_MODE_MAP_VH
`define SBC_MODE_MAP_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_FREQ_HZ 50000000
`define INIT_TIMEOUT_MS 256
`define INIT_TIMEOUT_CYC ((`CLK_FREQ_HZ / 1000) * `INIT_TIMEOUT_MS)
`define RESET_DELAY_SHORT_US 2000
`define RESET_DELAY_LONG_US 20000
`define RESET_DELAY_SHORT_CYC ((`CLK_FREQ_HZ / 1000000) * `RESET_DELAY_SHORT_US)
`define RESET_DELAY_LONG_CYC ((`CLK_FREQ_HZ / 1000000) * `RESET_DELAY_LONG_US)
// ----------------------------------------
// Configuration codes
// ----------------------------------------
`define CFG_DEV 3'h0
`define CFG_1 3'h1
`define CFG_2 3'h2
`define CFG_3 3'h3
`define CFG_4 3'h4
// ----------------------------------------
// Limp reason codes
// ----------------------------------------
`define LIMP_NONE 3'h0
`define LIMP_INIT_TIMEOUT 3'h1
`define LIMP_RESET_CLAMP 3'h2
`define LIMP_WD_FAIL 3'h3
`define LIMP_UV_TIMEOUT 3'h4
`define LIMP_THERMAL 3'h5
`define LIMP_FS_WAKE 3'h6
// ----------------------------------------
// Restart reason codes
// ----------------------------------------
`define RST_NONE 2'h0
`define RST_EXT_LOW 2'h1
`define RST_UNDERVOLT 2'h2
`define RST_WD_OR_CMD 2'h3
// ----------------------------------------
// Wake status selection
// ----------------------------------------
`define WAKE_SEL_WAKE 3'h0
`endif

/* verilog/delay_timer.v */
// Loadable down-counter that pulses when a programmed delay runs out
`timescale 1ns/10ps
module delay_timer #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_n_in,
  // Control
  input wire start_in,
  input wire stop_in,
  input wire [WIDTH-1:0] count_in,
  // Status
  output reg done_out
);

reg [WIDTH-1:0] count_ff;
reg run_ff;

always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    count_ff <= {WIDTH{1'b0}};
    run_ff <= 1'b0;
    done_out <= 1'b0;
  end else begin
    done_out <= 1'b0;
    if (stop_in) begin
      run_ff <= 1'b0;
    end else if (start_in) begin
      count_ff <= count_in;
      run_ff <= 1'b1;
    end else if (run_ff) begin
      if (count_ff <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        run_ff <= 1'b0;
        done_out <= 1'b1;
      end else begin
        count_ff <= count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
end

endmodule

/* verilog/sbc_restart_failsafe_control.v */
// Restart, fail-safe and development mode sequencer of the system basis chip
`timescale 1ns/10ps
`include "sbc_mode_map.vh"
module sbc_restart_failsafe_control #(
  parameter INIT_TIMEOUT_CYC = `INIT_TIMEOUT_CYC,
  parameter RST_SHORT_CYC = `RESET_DELAY_SHORT_CYC,
  parameter RST_LONG_CYC = `RESET_DELAY_LONG_CYC
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_n_in,
  // Pins from outside
  input wire test_pin_in,
  input wire [1:0] config_sel_in,
  input wire reset_line_in,
  // Analog monitors
  input wire main_uv_in,
  input wire main_uv_timeout_in,
  input wire supply_above_limp_uv_in,
  input wire thermal_shutdown_in,
  input wire reset_clamped_in,
  // Watchdog and wake
  input wire wd_fail_in,
  input wire wake_event_in,
  input wire [3:0] wake_source_in,
  // Commands decoded from SPI
  input wire cmd_normal_in,
  input wire cmd_flash_in,
  input wire cmd_sleep_in,
  input wire cmd_stop_in,
  input wire cmd_restart_in,
  input wire reset_delay_long_in,
  input wire limp_set_in,
  input wire limp_clear_in,
  input wire spi_frame_done_in,
  input wire reason_read_in,
  input wire wake_read_in,
  // Mode and pin outputs
  output reg [5:0] mode_out,
  output reg reset_output_n_out,
  output reg limp_home_output_out,
  output reg main_regulator_en_out,
  output reg aux_regulator_en_out,
  output reg trx_wake_capable_out,
  output reg int_n_out,
  // Status for SPI readout
  output reg [2:0] config_out,
  output reg [2:0] limp_reason_bits_out,
  output reg [1:0] restart_reason_bits_out,
  output reg [3:0] wake_status_bits_out,
  output reg [2:0] wake_sel_out,
  output reg wd_reset_bit_out,
  output reg report_reason_out
);

// ----------------------------------------
// Mode states
// ----------------------------------------
localparam ST_INIT = 6'h01;
localparam ST_NORMAL = 6'h02;
localparam ST_FLASH = 6'h04;
localparam ST_SLEEP = 6'h08;
localparam ST_STOP = 6'h10;
localparam ST_RESTART = 6'h20;
localparam ST_FAILSAFE = 6'h00;
localparam TW = 24;

// Fail-safe has its own flag so that the one-hot code stays six wide
reg failsafe_ff;
reg [5:0] state_ff;
reg [5:0] nxt_state;
reg nxt_failsafe;

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [2:0] rst_sync_ff;
reg [2:0] test_sync_ff;
reg rst_line_ff;
reg [1:0] fill_ff;
reg [3:0] own_rel_ff;
reg cfg_taken_ff;
reg [2:0] cfg_ff;
reg wd_cnt_ff;
reg thermal_latch_ff;
reg [TW-1:0] init_cnt_ff;
reg init_tmo_ff;
reg timer_start_ff;

always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    rst_sync_ff <= 3'h7;
    test_sync_ff <= 3'h7;
    rst_line_ff <= 1'b1;
    fill_ff <= 2'h0;
    own_rel_ff <= 4'hF;
  end else begin
    rst_sync_ff <= {rst_sync_ff[1:0], reset_line_in};
    test_sync_ff <= {test_sync_ff[1:0], test_pin_in};
    if (rst_sync_ff[1] == rst_sync_ff[2]) begin
      rst_line_ff <= rst_sync_ff[2];
    end
    // Test pin is trusted only once the synchroniser has filled
    fill_ff <= {fill_ff[0], 1'b1};
    // Own reset release delayed by the line synchroniser latency
    own_rel_ff <= {own_rel_ff[2:0], reset_output_n_out};
  end
end

// ----------------------------------------
// Configuration taken once after reset release
// ----------------------------------------
always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    cfg_taken_ff <= 1'b0;
    cfg_ff <= `CFG_1;
  end else if (!cfg_taken_ff && fill_ff[1] && test_sync_ff[1] == test_sync_ff[2]) begin
    cfg_taken_ff <= 1'b1;
    if (!test_sync_ff[2]) begin
      cfg_ff <= `CFG_DEV;
    end else begin
      cfg_ff <= {1'b0, config_sel_in} + 3'h1;
    end
  end
end

wire dev_mode = (cfg_ff == `CFG_DEV);
wire ext_reset = !rst_line_ff && (&own_rel_ff);
wire wd_evt = wd_fail_in && !dev_mode;
wire clamp_fs = reset_clamped_in && (cfg_ff == `CFG_2 || cfg_ff == `CFG_4);
wire wd_fs = wd_evt && ((cfg_ff == `CFG_2) || (cfg_ff == `CFG_4 && wd_cnt_ff));
wire uv_fs = main_uv_timeout_in && supply_above_limp_uv_in;
wire fs_cause = wd_fs || uv_fs || thermal_shutdown_in || clamp_fs;
wire run_mode = (state_ff == ST_NORMAL) || (state_ff == ST_STOP) || (state_ff == ST_FLASH);
wire timer_done;

// Picks the limp reason code for a fail-safe entry
function [2:0] fs_code;
  input wd;
  input uv;
  input th;
  begin
    if (th) begin
      fs_code = `LIMP_THERMAL;
    end else if (uv) begin
      fs_code = `LIMP_UV_TIMEOUT;
    end else if (wd) begin
      fs_code = `LIMP_WD_FAIL;
    end else begin
      fs_code = `LIMP_RESET_CLAMP;
    end
  end
endfunction

// ----------------------------------------
// Init-mode timeout
// ----------------------------------------
always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    init_cnt_ff <= {TW{1'b0}};
    init_tmo_ff <= 1'b0;
  end else if (state_ff == ST_INIT && !failsafe_ff && reset_output_n_out) begin
    init_tmo_ff <= (init_cnt_ff == INIT_TIMEOUT_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1});
    init_cnt_ff <= init_cnt_ff + {{(TW-1){1'b0}}, 1'b1};
  end else begin
    init_cnt_ff <= {TW{1'b0}};
    init_tmo_ff <= 1'b0;
  end
end

// ----------------------------------------
// Next mode
// ----------------------------------------
always @* begin
  nxt_state = state_ff;
  nxt_failsafe = failsafe_ff;
  if (failsafe_ff) begin
    if (thermal_latch_ff) begin
      if (!thermal_shutdown_in) begin
        nxt_failsafe = 1'b0;
        nxt_state = ST_RESTART;
      end
    end else if (wake_event_in) begin
      nxt_failsafe = 1'b0;
      nxt_state = ST_RESTART;
    end
  end else if (fs_cause && state_ff != ST_SLEEP) begin
    nxt_failsafe = 1'b1;
    nxt_state = ST_FAILSAFE;
  end else if (ext_reset) begin
    nxt_state = ST_RESTART;
  end else begin
    case (state_ff)
      ST_INIT: begin
        if (cmd_normal_in) begin
          nxt_state = ST_NORMAL;
        end else if (cmd_flash_in) begin
          nxt_state = ST_FLASH;
        end else if (init_tmo_ff || reset_clamped_in) begin
          nxt_state = ST_RESTART;
        end
      end
      ST_NORMAL, ST_STOP, ST_FLASH: begin
        if (main_uv_in || wd_evt || reset_clamped_in) begin
          nxt_state = ST_RESTART;
        end else if (state_ff == ST_FLASH && cmd_restart_in) begin
          nxt_state = ST_RESTART;
        end else if (state_ff != ST_FLASH && cmd_sleep_in) begin
          nxt_state = ST_SLEEP;
        end else if (state_ff == ST_NORMAL && cmd_stop_in) begin
          nxt_state = ST_STOP;
        end else if (state_ff == ST_NORMAL && cmd_flash_in) begin
          nxt_state = ST_RESTART;
        end else if (state_ff == ST_STOP && cmd_normal_in) begin
          nxt_state = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (wake_event_in) begin
          nxt_state = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (timer_done) begin
          nxt_state = ST_NORMAL;
        end
      end
      default: begin
        nxt_state = ST_INIT;
      end
    endcase
  end
end

always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    state_ff <= ST_INIT;
    failsafe_ff <= 1'b0;
    thermal_latch_ff <= 1'b0;
    wd_cnt_ff <= 1'b0;
    timer_start_ff <= 1'b0;
  end else begin
    state_ff <= nxt_state;
    failsafe_ff <= nxt_failsafe;
    timer_start_ff <= (nxt_state == ST_RESTART) && (state_ff != ST_RESTART || failsafe_ff);
    if (!failsafe_ff && nxt_failsafe) begin
      thermal_latch_ff <= thermal_shutdown_in;
    end else if (!nxt_failsafe) begin
      thermal_latch_ff <= 1'b0;
    end
    if (failsafe_ff && !nxt_failsafe && !thermal_latch_ff) begin
      wd_cnt_ff <= 1'b0;
    end else if (wd_evt && run_mode) begin
      wd_cnt_ff <= 1'b1;
    end else if (cmd_normal_in && state_ff == ST_NORMAL) begin
      wd_cnt_ff <= wd_cnt_ff;
    end
  end
end

// ----------------------------------------
// Reset-delay timer
// ----------------------------------------
delay_timer #(
  .WIDTH(TW)
) u_delay (
  .sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in),
  .start_in(timer_start_ff),
  .stop_in(failsafe_ff),
  .count_in(reset_delay_long_in ? RST_LONG_CYC[TW-1:0] : RST_SHORT_CYC[TW-1:0]),
  .done_out(timer_done)
);

// ----------------------------------------
// Outputs and reason latches
// ----------------------------------------
wire entering_rst = (nxt_state == ST_RESTART) && (state_ff != ST_RESTART || failsafe_ff);
wire entering_fs = nxt_failsafe && !failsafe_ff;
wire wd_restart = wd_evt && run_mode && entering_rst;

always @(posedge sys_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    mode_out <= ST_INIT;
    reset_output_n_out <= 1'b1;
    limp_home_output_out <= 1'b0;
    main_regulator_en_out <= 1'b1;
    aux_regulator_en_out <= 1'b0;
    trx_wake_capable_out <= 1'b0;
    int_n_out <= 1'b1;
    config_out <= `CFG_1;
    limp_reason_bits_out <= `LIMP_NONE;
    restart_reason_bits_out <= `RST_NONE;
    wake_status_bits_out <= 4'h0;
    wake_sel_out <= `WAKE_SEL_WAKE;
    wd_reset_bit_out <= 1'b0;
    report_reason_out <= 1'b0;
  end else begin
    mode_out <= nxt_state;
    config_out <= cfg_ff;
    reset_output_n_out <= !(nxt_state == ST_RESTART || nxt_failsafe);
    main_regulator_en_out <= !(nxt_failsafe || nxt_state == ST_SLEEP);
    aux_regulator_en_out <= run_mode && !nxt_failsafe;
    trx_wake_capable_out <= nxt_failsafe || nxt_state == ST_SLEEP;
    int_n_out <= !(wd_fail_in && dev_mode);
    // Limp-home: set by faults, never cleared by restart entry or exit
    if (entering_fs || (entering_rst && (init_tmo_ff || reset_clamped_in) && !ext_reset)) begin
      limp_home_output_out <= 1'b1;
    end else if (wd_restart && (cfg_ff == `CFG_1 || (cfg_ff == `CFG_3 && wd_cnt_ff))) begin
      limp_home_output_out <= 1'b1;
    end else if (limp_set_in && run_mode) begin
      limp_home_output_out <= 1'b1;
    end else if (limp_clear_in && run_mode && !failsafe_ff) begin
      limp_home_output_out <= 1'b0;
    end
    // Reason bits: a new cause wins over a clearing read
    if (entering_fs) begin
      limp_reason_bits_out <= fs_code(wd_fs, uv_fs, thermal_shutdown_in);
    end else if (failsafe_ff && entering_rst && !thermal_latch_ff) begin
      limp_reason_bits_out <= `LIMP_FS_WAKE;
    end else if (entering_rst && state_ff == ST_INIT && init_tmo_ff && !ext_reset) begin
      limp_reason_bits_out <= `LIMP_INIT_TIMEOUT;
    end else if (entering_rst && reset_clamped_in && !ext_reset) begin
      limp_reason_bits_out <= `LIMP_RESET_CLAMP;
    end else if (reason_read_in) begin
      limp_reason_bits_out <= `LIMP_NONE;
    end
    if (entering_rst && ext_reset) begin
      restart_reason_bits_out <= `RST_EXT_LOW;
    end else if (entering_rst && run_mode && main_uv_in) begin
      restart_reason_bits_out <= `RST_UNDERVOLT;
    end else if (entering_rst && run_mode && !reset_clamped_in) begin
      restart_reason_bits_out <= `RST_WD_OR_CMD;
    end else if (reason_read_in) begin
      restart_reason_bits_out <= `RST_NONE;
    end
    if ((entering_rst && state_ff == ST_SLEEP) || (failsafe_ff && entering_rst && !thermal_latch_ff)) begin
      wake_status_bits_out <= wake_source_in;
      wake_sel_out <= `WAKE_SEL_WAKE;
    end else if (wake_read_in) begin
      wake_status_bits_out <= 4'h0;
    end
    if (wd_fail_in && dev_mode) begin
      wd_reset_bit_out <= 1'b1;
    end else if (reason_read_in) begin
      wd_reset_bit_out <= 1'b0;
    end
    // First response in normal mode after a restart carries the reason
    if (state_ff == ST_RESTART && nxt_state == ST_NORMAL) begin
      report_reason_out <= 1'b1;
    end else if (spi_frame_done_in) begin
      report_reason_out <= 1'b0;
    end
  end
end

endmodule

/* testbench/host_mcu_model.sv */
// Host microcontroller model: reset line pull and status readout
`timescale 1ns/10ps
module host_mcu_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Bench control
  input wire logic pull_low_in,
  input wire logic read_req_in,
  // Device side
  input wire logic reset_output_n_in,
  output wire logic reset_line_out,
  output logic read_pulse_out
);
  // Open-drain line with pull-up: low while either side pulls
  assign reset_line_out = reset_output_n_in & ~pull_low_in;
  // One-cycle frame end that also reads the status bits
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_pulse_out <= 1'b0;
    end else begin
      read_pulse_out <= read_req_in;
    end
  end
endmodule

/* testbench/sbc_restart_failsafe_control_sva.sv */
// Checker of the mode sequencer outputs
`timescale 1ns/10ps
module sbc_restart_failsafe_control_chk #(
  parameter INIT_TIMEOUT_CYC = 50,
  parameter RST_LONG_CYC = 20
) (
  // Clock, reset and inputs
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic reset_line_in,
  input wire logic thermal_shutdown_in,
  input wire logic wd_fail_in,
  input wire logic wake_event_in,
  input wire logic [3:0] wake_source_in,
  // Outputs
  input wire logic [5:0] mode_out,
  input wire logic reset_output_n_out,
  input wire logic limp_home_output_out,
  input wire logic main_regulator_en_out,
  input wire logic aux_regulator_en_out,
  input wire logic trx_wake_capable_out,
  input wire logic int_n_out,
  input wire logic [2:0] config_out,
  input wire logic [3:0] wake_status_bits_out,
  input wire logic [2:0] wake_sel_out,
  input wire logic report_reason_out
);
  int rst_cnt_ff;
  int init_cnt_ff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------
  // Cycles spent in restart and init
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_cnt_ff <= 0;
      init_cnt_ff <= 0;
    end else begin
      rst_cnt_ff <= (mode_out == 6'h20) ? rst_cnt_ff + 1 : 0;
      init_cnt_ff <= (mode_out == 6'h01) ? init_cnt_ff + 1 : 0;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_restart_exits_alone: assert property (rst_cnt_ff <= RST_LONG_CYC + 16)
    else $error("restart mode held too long");
  a_restart_reset_low: assert property ((mode_out == 6'h20) |-> !reset_output_n_out)
    else $error("reset output high in restart");
  a_normal_reset_high: assert property ((mode_out == 6'h02) |-> reset_output_n_out)
    else $error("reset output low in normal");
  a_limp_kept_restart: assert property ($rose(mode_out == 6'h20) && $past(limp_home_output_out)
      |-> limp_home_output_out ##1 (mode_out != 6'h20 || limp_home_output_out))
    else $error("limp output dropped around restart");
  a_report_after_restart: assert property ($past(mode_out) == 6'h20 && mode_out == 6'h02
      |-> report_reason_out)
    else $error("reason report missing after restart");
  a_sleep_wake_restart: assert property ((mode_out == 6'h08 && wake_event_in) |=>
      (mode_out == 6'h20 && wake_sel_out == 3'h0 && int_n_out
      && wake_status_bits_out == $past(wake_source_in)))
    else $error("sleep wake handled wrongly");
  a_ext_reset_enters: assert property ($fell(reset_line_in) && reset_output_n_out && mode_out == 6'h02
      |-> ##[1:6] mode_out == 6'h20)
    else $error("external reset not followed by restart");
  a_failsafe_outputs: assert property ((mode_out == 6'h00) |-> (!main_regulator_en_out
      && !aux_regulator_en_out && trx_wake_capable_out && limp_home_output_out))
    else $error("fail-safe outputs wrong");
  a_failsafe_wake_back: assert property ((mode_out == 6'h00 && wake_event_in && !thermal_shutdown_in)
      |=> mode_out == 6'h20)
    else $error("fail-safe wake did not restart");
  a_dev_wd_interrupt: assert property ((config_out == 3'h0 && mode_out == 6'h02 && wd_fail_in)
      |=> (mode_out == 6'h02 && !int_n_out && reset_output_n_out))
    else $error("development watchdog fault handled wrongly");
  a_cfg2_wd_failsafe: assert property ((config_out == 3'h2 && mode_out == 6'h02 && wd_fail_in)
      |=> mode_out == 6'h00)
    else $error("config 2 watchdog fault missed fail-safe");
  a_init_bounded: assert property (init_cnt_ff <= INIT_TIMEOUT_CYC + 8)
    else $error("init mode held too long");
  c_failsafe: cover property (mode_out == 6'h00);
  c_restart: cover property ($rose(mode_out == 6'h20));
  c_dev_int: cover property (!int_n_out);
endmodule
bind sbc_restart_failsafe_control sbc_restart_failsafe_control_chk #(
  .INIT_TIMEOUT_CYC(INIT_TIMEOUT_CYC), .RST_LONG_CYC(RST_LONG_CYC)) chk_i (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reset_line_in(reset_line_in),
  .thermal_shutdown_in(thermal_shutdown_in), .wd_fail_in(wd_fail_in), .wake_event_in(wake_event_in),
  .wake_source_in(wake_source_in), .mode_out(mode_out), .reset_output_n_out(reset_output_n_out),
  .limp_home_output_out(limp_home_output_out), .main_regulator_en_out(main_regulator_en_out),
  .aux_regulator_en_out(aux_regulator_en_out), .trx_wake_capable_out(trx_wake_capable_out),
  .int_n_out(int_n_out), .config_out(config_out), .wake_status_bits_out(wake_status_bits_out),
  .wake_sel_out(wake_sel_out), .report_reason_out(report_reason_out));

/* testbench/tb_top.sv */
// Testbench for the restart and fail-safe mode sequencer
`timescale 1ns/10ps
`include "sbc_mode_map.vh"
module tb_top;
  logic sys_clk_in, reset_n_in, test_pin_in, pull_low, read_req, uv, uv_to, sup_ok, therm, clamp, dly_long;
  logic [1:0] config_sel_in;
  logic [3:0] wake_source_in;
  logic [9:0] pls;
  wire reset_line, read_pulse, rst_n_o, limp, main_en, aux_en, trx_wk, int_n, wd_bit, report;
  wire [5:0] mode;
  wire [2:0] cfg, limp_rsn, wake_sel;
  wire [1:0] rst_rsn;
  wire [3:0] wake_st;
  int err_total, total_checks;
  sbc_restart_failsafe_control #(.INIT_TIMEOUT_CYC(50), .RST_SHORT_CYC(10), .RST_LONG_CYC(20))
    sbc_restart_failsafe_control_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .test_pin_in(test_pin_in),
    .config_sel_in(config_sel_in), .reset_line_in(reset_line), .main_uv_in(uv),
    .main_uv_timeout_in(uv_to), .supply_above_limp_uv_in(sup_ok), .thermal_shutdown_in(therm),
    .reset_clamped_in(clamp), .wd_fail_in(pls[0]), .wake_event_in(pls[1]), .wake_source_in(wake_source_in),
    .cmd_normal_in(pls[2]), .cmd_flash_in(pls[4]), .cmd_sleep_in(pls[3]), .cmd_stop_in(pls[5]),
    .cmd_restart_in(pls[6]), .reset_delay_long_in(dly_long), .limp_set_in(pls[7]), .limp_clear_in(pls[8]),
    .spi_frame_done_in(read_pulse), .reason_read_in(read_pulse), .wake_read_in(read_pulse),
    .mode_out(mode), .reset_output_n_out(rst_n_o), .limp_home_output_out(limp),
    .main_regulator_en_out(main_en), .aux_regulator_en_out(aux_en), .trx_wake_capable_out(trx_wk),
    .int_n_out(int_n), .config_out(cfg), .limp_reason_bits_out(limp_rsn),
    .restart_reason_bits_out(rst_rsn), .wake_status_bits_out(wake_st), .wake_sel_out(wake_sel),
    .wd_reset_bit_out(wd_bit), .report_reason_out(report));
  host_mcu_model host_mcu_model_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .pull_low_in(pull_low), .read_req_in(read_req),
    .reset_output_n_in(rst_n_o), .reset_line_out(reset_line), .read_pulse_out(read_pulse));
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk_val(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_val({5'h0, got}, {5'h0, exp});
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task pulse(input int b);
    pls[b] = 1'b1;
    step(1);
    pls[b] = 1'b0;
  endtask
  task wait_mode(input logic [5:0] m, input int n);
    for (int i = 0; i < n && mode !== m; i++) step(1);
    chk_val(mode, m);
    if (mode !== m) complete_run();
  endtask
  task host_read();
    read_req = 1'b1;
    step(1);
    read_req = 1'b0;
    step(2);
  endtask
  task rst_dut(input logic t, input logic [1:0] s);
    reset_n_in = 1'b0;
    test_pin_in = t;
    config_sel_in = s;
    step(6);
    reset_n_in = 1'b1;
    step(8);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_init_timeout();
    rst_dut(1'b1, 2'h0);
    chk_val({3'h0, cfg}, 6'h01);
    wait_mode(6'h20, 120);
    chk_bit(limp, 1'b1);
    chk_val({3'h0, limp_rsn}, {3'h0, `LIMP_INIT_TIMEOUT});
    chk_bit(rst_n_o, 1'b0);
    wait_mode(6'h02, 100);
    chk_bit(rst_n_o, 1'b1);
    chk_bit(report, 1'b1);
    host_read();
    chk_bit(report, 1'b0);
    chk_val({3'h0, limp_rsn}, 6'h00);
    $display("test init_timeout done");
  endtask
  task test_wd_ext_uv();
    pulse(0);
    chk_val(mode, 6'h20);
    chk_val({4'h0, rst_rsn}, {4'h0, `RST_WD_OR_CMD});
    wait_mode(6'h02, 100);
    chk_bit(limp, 1'b1);
    host_read();
    chk_val({4'h0, rst_rsn}, 6'h00);
    pull_low = 1'b1;
    wait_mode(6'h20, 10);
    pull_low = 1'b0;
    chk_val({4'h0, rst_rsn}, {4'h0, `RST_EXT_LOW});
    chk_bit(limp, 1'b1);
    wait_mode(6'h02, 100);
    uv = 1'b1;
    step(1);
    uv = 1'b0;
    chk_val(mode, 6'h20);
    chk_val({4'h0, rst_rsn}, {4'h0, `RST_UNDERVOLT});
    wait_mode(6'h02, 100);
    clamp = 1'b1;
    step(1);
    clamp = 1'b0;
    chk_val(mode, 6'h20);
    chk_val({3'h0, limp_rsn}, {3'h0, `LIMP_RESET_CLAMP});
    wait_mode(6'h02, 100);
    host_read();
    $display("test wd_ext_uv done");
  endtask
  task test_cmds_sleep();
    pulse(8);
    chk_bit(limp, 1'b0);
    pulse(7);
    chk_bit(limp, 1'b1);
    pulse(5);
    chk_val(mode, 6'h10);
    pulse(2);
    pulse(4);
    chk_val(mode, 6'h20);
    wait_mode(6'h02, 100);
    pulse(3);
    chk_val(mode, 6'h08);
    wake_source_in = 4'hA;
    pulse(1);
    chk_val(mode, 6'h20);
    chk_val({2'h0, wake_st}, 6'h0A);
    chk_val({3'h0, wake_sel}, {3'h0, `WAKE_SEL_WAKE});
    chk_bit(int_n, 1'b1);
    wait_mode(6'h02, 100);
    host_read();
    $display("test cmds_sleep done");
  endtask
  task test_thermal();
    therm = 1'b1;
    step(1);
    chk_val(mode, 6'h00);
    chk_bit(main_en, 1'b0);
    chk_bit(trx_wk, 1'b1);
    chk_val({3'h0, limp_rsn}, {3'h0, `LIMP_THERMAL});
    pulse(1);
    chk_val(mode, 6'h00);
    dly_long = 1'b1;
    therm = 1'b0;
    wait_mode(6'h20, 10);
    step(15);
    chk_val(mode, 6'h20);
    wait_mode(6'h02, 100);
    dly_long = 1'b0;
    host_read();
    $display("test thermal done");
  endtask
  task test_cfg2_cfg4();
    rst_dut(1'b1, 2'h1);
    chk_val({3'h0, cfg}, 6'h02);
    pulse(4);
    chk_val(mode, 6'h04);
    pulse(6);
    chk_val(mode, 6'h20);
    chk_val({4'h0, rst_rsn}, {4'h0, `RST_WD_OR_CMD});
    wait_mode(6'h02, 100);
    pulse(0);
    chk_val(mode, 6'h00);
    chk_bit(aux_en, 1'b0);
    pulse(1);
    chk_val(mode, 6'h20);
    chk_val({3'h0, limp_rsn}, {3'h0, `LIMP_FS_WAKE});
    wait_mode(6'h02, 100);
    chk_bit(report, 1'b1);
    rst_dut(1'b1, 2'h3);
    pulse(2);
    pulse(0);
    chk_val(mode, 6'h20);
    wait_mode(6'h02, 100);
    pulse(0);
    chk_val(mode, 6'h00);
    $display("test cfg2_cfg4 done");
  endtask
  task test_dev();
    rst_dut(1'b0, 2'h0);
    chk_val({3'h0, cfg}, 6'h00);
    pulse(2);
    pulse(0);
    chk_val(mode, 6'h02);
    chk_bit(int_n, 1'b0);
    chk_bit(rst_n_o, 1'b1);
    chk_bit(wd_bit, 1'b1);
    uv = 1'b1;
    step(1);
    uv = 1'b0;
    chk_val(mode, 6'h20);
    wait_mode(6'h02, 100);
    uv_to = 1'b1;
    step(1);
    uv_to = 1'b0;
    chk_val(mode, 6'h00);
    chk_val({3'h0, limp_rsn}, {3'h0, `LIMP_UV_TIMEOUT});
    $display("test dev done");
  endtask
  initial begin
    {pull_low, read_req, uv, uv_to, therm, clamp, dly_long} = 7'h00;
    sup_ok = 1'b1;
    pls = 10'h000;
    wake_source_in = 4'h0;
    err_total = 0;
    total_checks = 0;
    test_init_timeout();
    test_wd_ext_uv();
    test_cmds_sleep();
    test_thermal();
    test_cfg2_cfg4();
    test_dev();
    complete_run();
  end
endmodule
